// ==== logic/gate_input_decoder.sv ====
// Decoder end: turns six gate inputs into gate commands
`timescale 1ns/1ps
`include "gate_decoder_consts.svh"
module gate_input_decoder (
    input  wire logic                         mclk,
    input  wire logic                         rst,
    gate_link_if.decoder                      link,
    input  wire gate_decoder_pkg::scheme_type scheme_select,
    input  wire logic                         single_pwm_freewheel_select,
    output logic [2:0]                        upper_gate_out,
    output logic [2:0]                        lower_gate_out
);
    import gate_decoder_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Input synchroniser
    logic [5:0] meta_q, meta_d;
    logic [5:0] sync_q, sync_d;

    always_comb begin
        meta_d = {link.low_side_input, link.high_side_input};
        sync_d = meta_q;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= 6'h00;
            sync_q <= 6'h00;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Decode
    logic [2:0]     hin;
    logic [2:0]     lin;
    logic           pwm;
    phase_bits_type state_bits;
    logic [2:0]     upper_d, upper_q;
    logic [2:0]     lower_d, lower_q;
    logic [2:0]     six_up, six_lo, three_up, three_lo;
    logic [2:0]     pwm_phase;
    logic [2:0]     on_low;

    assign hin = sync_q[2:0];
    assign lin = sync_q[5:3];
    assign pwm = hin[0];

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_phase
            assign six_up[i]   = hin[i] & ~lin[i];
            assign six_lo[i]   = lin[i] & ~hin[i];
            assign three_up[i] = lin[i] & hin[i];
            assign three_lo[i] = lin[i] & ~hin[i];
        end
    endgenerate

    always_comb begin
        // State bits from A-low, B-high, B-low
        state_bits = {lin[0], hin[1], lin[1]};
        if (hin[2] && state_bits != `STATE_STOP &&
            state_bits != `STATE_ALIGN) begin
            state_bits = ~state_bits;
        end
    end

    always_comb begin
        pwm_phase = 3'h0;
        on_low    = 3'h0;
        case (state_bits)
            3'b110: begin pwm_phase = 3'b010; on_low = 3'b100; end
            3'b100: begin pwm_phase = 3'b001; on_low = 3'b100; end
            3'b101: begin pwm_phase = 3'b001; on_low = 3'b010; end
            3'b001: begin pwm_phase = 3'b100; on_low = 3'b010; end
            3'b011: begin pwm_phase = 3'b100; on_low = 3'b001; end
            3'b010: begin pwm_phase = 3'b010; on_low = 3'b001; end
            // Align PWM on A, B and C low
            3'b111: begin pwm_phase = 3'b001; on_low = 3'b110; end
            default: begin pwm_phase = 3'b000; on_low = 3'b000; end
        endcase
    end

    always_comb begin
        upper_d = 3'h0;
        lower_d = 3'h0;
        case (scheme_select)
            `SCHEME_SIX_INPUT: begin
                upper_d = six_up;
                lower_d = six_lo;
            end
            `SCHEME_THREE_INPUT: begin
                upper_d = three_up;
                lower_d = three_lo;
            end
            `SCHEME_SINGLE_PWM: begin
                upper_d = pwm_phase & {3{pwm}};
                lower_d = on_low | (pwm_phase & {3{~pwm}});
                if (single_pwm_freewheel_select) begin
                    lower_d = on_low;
                end
                if (!lin[2]) begin
                    upper_d = 3'h0;
                    lower_d = 3'h7;
                end
            end
            `SCHEME_INDEPENDENT: begin
                // No interlock, both may be on
                upper_d = hin;
                lower_d = lin;
            end
            default: begin
                upper_d = 3'h0;
                lower_d = 3'h0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            upper_q <= 3'h0;
            lower_q <= 3'h0;
        end else begin
            upper_q <= upper_d;
            lower_q <= lower_d;
        end
    end

    assign upper_gate_out = upper_q;
    assign lower_gate_out = lower_q;
endmodule // gate_input_decoder

// ==== logic/gate_decoder_consts.svh ====
// Constants for the gate input decoder
`ifndef GATE_DECODER_CONSTS_SVH
`define GATE_DECODER_CONSTS_SVH
`define SCHEME_SIX_INPUT    2'b00
`define SCHEME_THREE_INPUT  2'b01
`define SCHEME_SINGLE_PWM   2'b10
`define SCHEME_INDEPENDENT  2'b11
`define STATE_STOP          3'h0
`define STATE_ALIGN         3'h7
`define SYNC_STAGES         2
`endif

// ==== logic/gate_decoder_pkg.sv ====
// Types shared by both ends of the gate input link
package gate_decoder_pkg;
    typedef logic [1:0] scheme_type;
    typedef logic [2:0] phase_bits_type;
endpackage

// ==== logic/gate_link_if.sv ====
// Link between motor controller and gate input decoder
`timescale 1ns/1ps
interface gate_link_if;
    logic [2:0] high_side_input;
    logic [2:0] low_side_input;
    modport controller (output high_side_input, output low_side_input);
    modport decoder    (input high_side_input, input low_side_input);
endinterface // gate_link_if

// ==== logic/motor_controller_end.sv ====
// Controller end: drives the six gate inputs with scheme-change safety
`timescale 1ns/1ps
`include "gate_decoder_consts.svh"
module motor_controller_end (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    gate_link_if.controller                  link,
    input  wire gate_decoder_pkg::scheme_type scheme_request,
    input  wire logic [2:0]                  high_request,
    input  wire logic [2:0]                  low_request,
    input  wire logic                        use_hiz,
    input  wire logic                        use_brake,
    input  wire logic                        use_reverse,
    output gate_decoder_pkg::scheme_type     scheme_out,
    output logic                             scheme_busy
);
    import gate_decoder_pkg::*;

    logic [2:0]  high_q, high_d;
    logic [2:0]  low_q, low_d;
    scheme_type  scheme_q, scheme_d;
    logic        busy_q, busy_d;

    always_comb begin
        high_d   = high_request;
        low_d    = low_request;
        scheme_d = scheme_q;
        busy_d   = 1'b0;
        if (scheme_request != scheme_q) begin
            busy_d = 1'b1;
            high_d = 3'h0;
            low_d  = 3'h0;
            // Change only after a cycle of all-low inputs
            if (busy_q && high_q == 3'h0 && low_q == 3'h0) begin
                scheme_d = scheme_request;
            end
        end else if (scheme_q == `SCHEME_THREE_INPUT && !use_hiz) begin
            low_d = 3'h7;
        end else if (scheme_q == `SCHEME_SINGLE_PWM) begin
            if (!use_brake) begin
                low_d[2] = 1'b1;
            end
            if (!use_reverse) begin
                high_d[2] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            high_q   <= 3'h0;
            low_q    <= 3'h0;
            scheme_q <= `SCHEME_SIX_INPUT;
            busy_q   <= 1'b0;
        end else begin
            high_q   <= high_d;
            low_q    <= low_d;
            scheme_q <= scheme_d;
            busy_q   <= busy_d;
        end
    end

    // State bits driven on A-low, B-high, B-low
    assign link.high_side_input = high_q;
    assign link.low_side_input  = low_q;
    assign scheme_out  = scheme_q;
    assign scheme_busy = busy_q;
endmodule // motor_controller_end

// ==== verification/gate_link_props.sv ====
// Concurrent checks on the gate link and the decoder outputs
`timescale 1ns/1ps
module gate_link_props (
    input wire logic                         mclk,
    input wire logic                         rst,
    input wire logic [2:0]                   high_side_input,
    input wire logic [2:0]                   low_side_input,
    input wire gate_decoder_pkg::scheme_type scheme_select,
    input wire logic                         single_pwm_freewheel_select,
    input wire logic [2:0]                   upper_gate_out,
    input wire logic [2:0]                   lower_gate_out
);
    import gate_decoder_pkg::*;
    logic [2:0] h1, h2, h3, l1, l2, l3, r;
    scheme_type s1;
    logic       f1;
    // Delays match sync chain plus output register
    always_ff @(posedge mclk) begin
        {h3, h2, h1} <= {h2, h1, high_side_input};
        {l3, l2, l1} <= {l2, l1, low_side_input};
        r <= {r[1:0], rst};
        s1 <= scheme_select;
        f1 <= single_pwm_freewheel_select;
    end
    wire       ok  = (r == 3'h0);
    wire       pwm = ok && s1 == 2'h2;
    wire       gf  = pwm && l3[2] && !h3[2];
    wire       gr  = pwm && l3[2] && h3[2];
    wire [2:0] b   = {l3[0], h3[1], l3[1]};
    wire [2:0] u   = upper_gate_out;
    wire [2:0] w   = lower_gate_out;
    wire [2:0] lo  = l3 & ~h3;
    wire [2:0] al  = {2'h3, ~f1 & ~h3[0]};
    wire [2:0] bu  = {1'b0, h3[0], 1'b0};
    wire [2:0] bc  = {1'b1, al[0], 1'b0};
    wire [5:0] lk  = {high_side_input, low_side_input};
    ////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_six; ok && s1 == 2'h0 |-> u == (h3 & ~l3) && w == lo; endproperty
    a_six: assert property (p_six) else $error("six-input decode");
    property p_thr; ok && s1 == 2'h1 |-> u == (h3 & l3) && w == lo; endproperty
    a_thr: assert property (p_thr) else $error("three-input decode");
    property p_ind; ok && s1 == 2'h3 |-> u == h3 && w == l3; endproperty
    a_ind: assert property (p_ind) else $error("independent");
    property p_brk; pwm && !l3[2] |-> u == 3'h0 && w == 3'h7; endproperty
    a_brk: assert property (p_brk) else $error("brake");
    property p_aln;
        gf && b == 3'h7 |-> u == {2'h0, h3[0]} && w == al;
    endproperty
    a_aln: assert property (p_aln) else $error("align");
    property p_fwd; gf && b == 3'h6 |-> u == bu && w == bc; endproperty
    a_fwd: assert property (p_fwd) else $error("forward step");
    property p_rev; gr && b == 3'h1 |-> u == bu && w == bc; endproperty
    a_rev: assert property (p_rev) else $error("reverse step");
    property p_qui;
        $changed(scheme_select) |-> lk == 6'h0 && $past(lk) == 6'h0;
    endproperty
    a_qui: assert property (p_qui) else $error("scheme change");
endmodule // gate_link_props

// ==== verification/bldc_pwm_input_decoder_tb.sv ====
// Bench: controller end drives decoder end over the link
`timescale 1ns/1ps
module bldc_pwm_input_decoder_tb;
    import gate_decoder_pkg::*;
    // Flags: freewheel, hi-z use, brake use, reverse use
    typedef struct packed {
        scheme_type s;
        logic [3:0] f;
        logic [2:0] h, l, eu, el;
    } row_type;
    row_type rows [17] = '{
        '{2'h0,4'h7,3'h5,3'h6,3'h1,3'h2}, '{2'h1,4'h7,3'h3,3'h6,3'h2,3'h4},
        '{2'h1,4'h3,3'h2,3'h0,3'h2,3'h5}, '{2'h3,4'h7,3'h3,3'h6,3'h3,3'h6},
        '{2'h2,4'h7,3'h3,3'h5,3'h2,3'h4}, '{2'h2,4'h7,3'h1,3'h5,3'h1,3'h4},
        '{2'h2,4'h7,3'h1,3'h7,3'h1,3'h2}, '{2'h2,4'h7,3'h1,3'h6,3'h4,3'h2},
        '{2'h2,4'h7,3'h3,3'h6,3'h4,3'h1}, '{2'h2,4'h7,3'h3,3'h4,3'h2,3'h1},
        '{2'h2,4'h7,3'h5,3'h6,3'h2,3'h4}, '{2'h2,4'hf,3'h0,3'h5,3'h0,3'h4},
        '{2'h2,4'h7,3'h2,3'h7,3'h0,3'h7}, '{2'h2,4'h7,3'h1,3'h4,3'h0,3'h0},
        '{2'h2,4'h7,3'h3,3'h1,3'h0,3'h7}, '{2'h2,4'h5,3'h3,3'h1,3'h2,3'h4},
        '{2'h2,4'h6,3'h5,3'h6,3'h4,3'h2}};
    logic       mclk, rst, freewheel, use_hiz, use_brake, use_reverse;
    logic       busy;
    logic [2:0] high_request, low_request, upper_gate_out, lower_gate_out;
    scheme_type scheme_request, scheme_out;
    int         n_tests = 0, miscompares = 0, cycles = 0;
    gate_link_if i_gate_link_if ();
    motor_controller_end i_motor_controller_end (
        .mclk(mclk), .rst(rst), .link(i_gate_link_if),
        .scheme_request(scheme_request), .high_request(high_request),
        .low_request(low_request), .use_hiz(use_hiz), .use_brake(use_brake),
        .use_reverse(use_reverse), .scheme_out(scheme_out),
        .scheme_busy(busy));
    gate_input_decoder i_gate_input_decoder (
        .mclk(mclk), .rst(rst), .link(i_gate_link_if),
        .scheme_select(scheme_out), .single_pwm_freewheel_select(freewheel),
        .upper_gate_out(upper_gate_out), .lower_gate_out(lower_gate_out));
    gate_link_props i_gate_link_props (
        .mclk(mclk), .rst(rst), .scheme_select(scheme_out),
        .high_side_input(i_gate_link_if.high_side_input),
        .low_side_input(i_gate_link_if.low_side_input),
        .single_pwm_freewheel_select(freewheel),
        .upper_gate_out(upper_gate_out), .lower_gate_out(lower_gate_out));
    ////////////////////////////////////////////////////////////
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 600) begin
            miscompares++;
            end_sim;
        end
    end
    task chk(input logic [2:0] got, input logic [2:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("compares %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Scheme change costs three edges, decode three more
    task run_row(input row_type r);
        @(posedge mclk);
        scheme_request <= r.s;
        {freewheel, use_hiz, use_brake, use_reverse} <= r.f;
        high_request <= r.h;
        low_request <= r.l;
        @(posedge mclk);
        #1;
        // Busy must show while the old scheme still stands
        if (r.s != scheme_out) begin
            chk({2'h0, busy}, 3'h1);
        end
        repeat (7) @(posedge mclk);
        #1;
        chk(upper_gate_out, r.eu);
        chk(lower_gate_out, r.el);
    endtask
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        scheme_request = 2'h0;
        {freewheel, use_hiz, use_brake, use_reverse} = 4'h7;
        high_request = 3'h0;
        low_request = 3'h0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // Mid-run reset with gates on
        @(posedge mclk);
        rst <= 1'b1;
        scheme_request <= 2'h0;
        @(posedge mclk);
        #1;
        chk(upper_gate_out, 3'h0);
        chk(lower_gate_out, 3'h0);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        run_row(rows[0]);
        $display("reset test done");
        end_sim;
    end
endmodule // bldc_pwm_input_decoder_tb
